// file: pkg/adcs_consts.vh
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH

// cpu byte addresses
`define ADCS_OFF_RESULT_A_HI 4'h0
`define ADCS_OFF_RESULT_A_LO 4'h1
`define ADCS_OFF_RESULT_B_HI 4'h2
`define ADCS_OFF_RESULT_B_LO 4'h3
`define ADCS_OFF_RESULT_C_HI 4'h4
`define ADCS_OFF_RESULT_C_LO 4'h5
`define ADCS_OFF_RESULT_D_HI 4'h6
`define ADCS_OFF_RESULT_D_LO 4'h7
`define ADCS_OFF_CONTROL_STATUS 4'h8
`define ADCS_OFF_TRIGGER_CONTROL 4'h9

// control/status fields
`define ADCS_BIT_END_FLAG 7
`define ADCS_BIT_IRQ_ENABLE 6
`define ADCS_BIT_START 5
`define ADCS_BIT_SCAN 4
`define ADCS_BIT_TIME_SEL 3
`define ADCS_BIT_CHAN_HI 2
`define ADCS_BIT_CHAN_LO 0
`define ADCS_CSR_RESET 8'h00

// trigger control fields
`define ADCS_BIT_TRIG_ENABLE 7
`define ADCS_BIT_TRIG_RSVD0 0
`define ADCS_TRIG_RSVD_ONES 6'h3F

// result layout
`define ADCS_RESULT_RESET 16'h0000
`define ADCS_RESULT_LSB 6
`define ADCS_RESULT_PAD 6'h00

// conversion times in states (one state is one clk)
`define ADCS_STATES_FIRST_SLOW 8'd134
`define ADCS_STATES_FIRST_FAST 8'd70
`define ADCS_STATES_NEXT_SLOW 8'd128
`define ADCS_STATES_NEXT_FAST 8'd66

`endif

// file: hw/adcs_conv_timer.v
`include "adcs_consts.vh"

module adcs_conv_timer (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire load,
  input wire abort,
  input wire [7:0] load_val,
  // status
  output wire busy,
  output wire done
);
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;

  always @* begin
    cnt_next = cnt_reg;
    if (abort) begin
      cnt_next = 8'h00;
    end else if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != 8'h00) begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy = (cnt_reg != 8'h00);
  // the last state of the count; abort suppresses a finish in the same cycle
  assign done = (cnt_reg == 8'h01) && !abort;
endmodule

// file: hw/adcs_trig_edge.v
module adcs_trig_edge (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // pin and enable
  input wire ext_trigger_n,
  input wire enable,
  // event
  output wire fall
);
  reg prev_reg;

  // reset to high so a pin held low at release gives an edge if enable is high in the first cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= ext_trigger_n;
    end
  end

  assign fall = enable && prev_reg && !ext_trigger_n;
endmodule

// file: hw/adcs_top.v
`include "adcs_consts.vh"

module adcs_top (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // cpu access
  input wire [3:0] cpu_addr,
  input wire cpu_rd,
  input wire cpu_wr,
  input wire cpu_word,
  input wire [7:0] cpu_wdata,
  output wire [15:0] cpu_rdata,
  output wire cpu_rd_ack,
  // external trigger pin
  input wire ext_trigger_n,
  // analog core
  output wire [2:0] ana_chan,
  output wire ana_sample,
  input wire [9:0] ana_result,
  // interrupt request
  output wire conv_end_irq
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;
  localparam [7:0] CSR_RESET = `ADCS_CSR_RESET;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] chan_reg;
  reg [2:0] chan_next;

  reg conv_end_flag_reg;
  reg conv_end_flag_next;
  reg flag_seen_reg;
  reg flag_seen_next;
  reg conv_end_irq_enable_reg;
  reg conv_start_bit_reg;
  reg conv_start_bit_next;
  reg scan_mode_reg;
  reg conv_time_select_reg;
  reg [2:0] chan_sel_reg;
  reg trigger_enable_bit_reg;
  reg trig_rsvd0_reg;
  reg conv_end_irq_enable_next;
  reg scan_mode_next;
  reg conv_time_select_next;
  reg [2:0] chan_sel_next;
  reg trigger_enable_bit_next;
  reg trig_rsvd0_next;

  reg [7:0] temp_lo_reg;
  reg [15:0] rdata_reg;
  reg [15:0] rdata_next;
  reg rd_ack_reg;

  reg load_conv;
  reg [7:0] load_val;
  reg store_result;
  reg set_end_flag;
  reg hw_clear_start;

  wire [15:0] result_word [0:3];
  wire conv_done;
  wire trig_fall;
  wire csr_wr;
  wire trg_wr;
  wire csr_rd;
  wire [7:0] csr_value;
  wire [7:0] trg_value;
  wire abort_conv;
  wire [2:0] first_chan;
  wire last_in_pass;
  wire [7:0] first_states;
  wire [7:0] next_states;
  wire res_rd;
  wire res_hi_rd;
  wire [1:0] res_sel;

  assign csr_wr = cpu_wr && (cpu_addr == `ADCS_OFF_CONTROL_STATUS);
  assign trg_wr = cpu_wr && (cpu_addr == `ADCS_OFF_TRIGGER_CONTROL);
  assign csr_rd = cpu_rd && (cpu_addr == `ADCS_OFF_CONTROL_STATUS);

  // even result address is an upper byte; a word read counts as one too
  assign res_rd = cpu_rd && !cpu_addr[3];
  assign res_hi_rd = res_rd && (cpu_word || !cpu_addr[0]);
  assign res_sel = cpu_addr[2:1];

  assign csr_value = {conv_end_flag_reg, conv_end_irq_enable_reg, conv_start_bit_reg,
                      scan_mode_reg, conv_time_select_reg, chan_sel_reg};
  assign trg_value = {trigger_enable_bit_reg, `ADCS_TRIG_RSVD_ONES, trig_rsvd0_reg};

  adcs_trig_edge u_trig (
    .clk(clk),
    .rst_n(rst_n),
    .ext_trigger_n(ext_trigger_n),
    .enable(trigger_enable_bit_reg),
    .fall(trig_fall)
  );

  // a running conversion is dropped as soon as start reads zero
  assign abort_conv = (state_reg == ST_CONV) && !conv_start_bit_reg;

  adcs_conv_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(load_conv),
    .abort(abort_conv),
    .load_val(load_val),
    .busy(),
    .done(conv_done)
  );

  // scan starts at input 0 or 4; single uses the field directly
  assign first_chan = scan_mode_reg ? {chan_sel_reg[`ADCS_BIT_CHAN_HI], 2'b00}
                                    : chan_sel_reg;
  assign last_in_pass = (chan_reg[1:0] == chan_sel_reg[1:0]);

  // the first conversion of a start is longer than the back-to-back ones of a scan
  assign first_states = conv_time_select_reg ? `ADCS_STATES_FIRST_FAST
                                             : `ADCS_STATES_FIRST_SLOW;
  assign next_states = conv_time_select_reg ? `ADCS_STATES_NEXT_FAST
                                            : `ADCS_STATES_NEXT_SLOW;

  // sequencer
  always @* begin
    state_next = state_reg;
    chan_next = chan_reg;
    load_conv = 1'b0;
    load_val = first_states;
    store_result = 1'b0;
    set_end_flag = 1'b0;
    hw_clear_start = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // only the first channel is taken here; scan mode and the channel field are read again while converting
        if (conv_start_bit_reg) begin
          chan_next = first_chan;
          load_conv = 1'b1;
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abort_conv) begin
          state_next = ST_IDLE;
        end else if (conv_done) begin
          store_result = 1'b1;
          if (!scan_mode_reg) begin
            set_end_flag = 1'b1;
            hw_clear_start = 1'b1;
            state_next = ST_IDLE;
          end else begin
            load_conv = 1'b1;
            load_val = next_states;
            if (last_in_pass) begin
              set_end_flag = 1'b1;
              chan_next = first_chan;
            end else begin
              chan_next = chan_reg + 3'd1;
            end
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      chan_reg <= 3'b000;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
    end
  end

  // result registers, one per position in a group
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_result
      reg [9:0] value_reg;
      always @(posedge clk) begin
        if (!rst_n) begin
          value_reg <= 10'h000;
        end else if (store_result && (chan_reg[1:0] == gi)) begin
          value_reg <= ana_result;
        end
      end
      // no write path reaches value_reg
      assign result_word[gi] = {value_reg, `ADCS_RESULT_PAD};
    end
  endgenerate

  // end flag: hardware set wins over a software clear in the same cycle
  always @* begin
    conv_end_flag_next = conv_end_flag_reg;
    flag_seen_next = flag_seen_reg;
    if (csr_rd && conv_end_flag_reg) begin
      flag_seen_next = 1'b1;
    end
    if (csr_wr) begin
      if (!cpu_wdata[`ADCS_BIT_END_FLAG] && flag_seen_reg) begin
        conv_end_flag_next = 1'b0;
      end
      // writing one has no effect on the flag itself
      flag_seen_next = 1'b0;
    end
    if (set_end_flag) begin
      conv_end_flag_next = 1'b1;
    end
  end

  // start bit: software write, trigger set, automatic clear
  always @* begin
    conv_start_bit_next = conv_start_bit_reg;
    if (hw_clear_start) begin
      conv_start_bit_next = 1'b0;
    end
    if (csr_wr) begin
      conv_start_bit_next = cpu_wdata[`ADCS_BIT_START];
    end
    if (trig_fall) begin
      conv_start_bit_next = 1'b1;
    end
  end

  // plain read/write control fields take the written byte as it stands
  always @* begin
    conv_end_irq_enable_next = conv_end_irq_enable_reg;
    scan_mode_next = scan_mode_reg;
    conv_time_select_next = conv_time_select_reg;
    chan_sel_next = chan_sel_reg;
    trigger_enable_bit_next = trigger_enable_bit_reg;
    trig_rsvd0_next = trig_rsvd0_reg;
    if (csr_wr) begin
      conv_end_irq_enable_next = cpu_wdata[`ADCS_BIT_IRQ_ENABLE];
      scan_mode_next = cpu_wdata[`ADCS_BIT_SCAN];
      conv_time_select_next = cpu_wdata[`ADCS_BIT_TIME_SEL];
      chan_sel_next = cpu_wdata[`ADCS_BIT_CHAN_HI:`ADCS_BIT_CHAN_LO];
    end
    // bit 0 of the trigger register is only stored and read back, it drives nothing
    if (trg_wr) begin
      trigger_enable_bit_next = cpu_wdata[`ADCS_BIT_TRIG_ENABLE];
      trig_rsvd0_next = cpu_wdata[`ADCS_BIT_TRIG_RSVD0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      conv_end_flag_reg <= CSR_RESET[`ADCS_BIT_END_FLAG];
      flag_seen_reg <= 1'b0;
      conv_end_irq_enable_reg <= CSR_RESET[`ADCS_BIT_IRQ_ENABLE];
      conv_start_bit_reg <= CSR_RESET[`ADCS_BIT_START];
      scan_mode_reg <= CSR_RESET[`ADCS_BIT_SCAN];
      conv_time_select_reg <= CSR_RESET[`ADCS_BIT_TIME_SEL];
      chan_sel_reg <= CSR_RESET[`ADCS_BIT_CHAN_HI:`ADCS_BIT_CHAN_LO];
      trigger_enable_bit_reg <= 1'b0;
      trig_rsvd0_reg <= 1'b0;
    end else begin
      conv_end_flag_reg <= conv_end_flag_next;
      flag_seen_reg <= flag_seen_next;
      conv_start_bit_reg <= conv_start_bit_next;
      conv_end_irq_enable_reg <= conv_end_irq_enable_next;
      scan_mode_reg <= scan_mode_next;
      conv_time_select_reg <= conv_time_select_next;
      chan_sel_reg <= chan_sel_next;
      trigger_enable_bit_reg <= trigger_enable_bit_next;
      trig_rsvd0_reg <= trig_rsvd0_next;
    end
  end

  // read path; data comes back registered one cycle after the strobe
  always @* begin
    rdata_next = 16'h0000;
    // addresses above the trigger register fall through and read zero
    case (cpu_addr)
      `ADCS_OFF_CONTROL_STATUS: begin
        rdata_next = {8'h00, csr_value};
      end
      `ADCS_OFF_TRIGGER_CONTROL: begin
        rdata_next = {8'h00, trg_value};
      end
      default: begin
        if (res_rd && cpu_word) begin
          rdata_next = result_word[res_sel];
        end else if (res_hi_rd) begin
          rdata_next = {8'h00, result_word[res_sel][15:8]};
        end else if (res_rd) begin
          rdata_next = {8'h00, temp_lo_reg};
        end
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      temp_lo_reg <= 8'h00;
      rdata_reg <= 16'h0000;
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= cpu_rd;
      if (cpu_rd) begin
        rdata_reg <= rdata_next;
      end
      // upper byte or word read freezes the lower half for a later byte read
      if (res_hi_rd) begin
        temp_lo_reg <= result_word[res_sel][7:0];
      end
    end
  end

  assign cpu_rdata = rdata_reg;
  assign cpu_rd_ack = rd_ack_reg;
  assign ana_chan = chan_reg;
  assign ana_sample = load_conv;
  assign conv_end_irq = conv_end_flag_reg && conv_end_irq_enable_reg;
endmodule

// file: tb/adcs_top_properties.sv
module adcs_top_properties (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // cpu access
  input wire [3:0] cpu_addr,
  input wire cpu_rd,
  input wire cpu_wr,
  input wire cpu_word,
  input wire [15:0] cpu_rdata,
  input wire cpu_rd_ack,
  // conversion
  input wire [2:0] ana_chan,
  input wire ana_sample,
  input wire conv_end_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] gap_reg;
  // saturates, and a csr write may abort, so only gaps between live samples count
  always @(posedge clk) begin
    if (!rst_n || (cpu_wr && cpu_addr == 4'h8)) gap_reg <= 8'hFF;
    else if (ana_sample) gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
  end
  sequence word_rd_s;
    cpu_rd && cpu_word && cpu_addr < 4'h8 && !cpu_addr[0];
  endsequence
  sequence padded_s;
    cpu_rd_ack && cpu_rdata[5:0] == 6'h00;
  endsequence
  rd_answer_a: assert property (cpu_rd |=> cpu_rd_ack)
    else $error("read not answered");
  ack_pulse_a: assert property (!cpu_rd |=> !cpu_rd_ack)
    else $error("stray read answer");
  word_pad_a: assert property (word_rd_s |=> padded_s)
    else $error("result low bits not zero");
  byte_upper_a: assert property (cpu_rd && !cpu_word |=> cpu_rdata[15:8] == 8'h00)
    else $error("byte read upper half not zero");
  unmapped_zero_a: assert property (cpu_rd && cpu_addr > 4'h9 |=> cpu_rdata == 16'h0000)
    else $error("unmapped read not zero");
  conv_gap_a: assert property (ana_sample |-> gap_reg >= 8'd65)
    else $error("conversion too short");
  irq_hold_a: assert property (conv_end_irq && !cpu_wr |=> conv_end_irq)
    else $error("end request dropped without write");
  chan_hold_a: assert property (!ana_sample |=> $stable(ana_chan))
    else $error("channel moved without a start");
endmodule

// file: tb/adcs_ana_model.sv
module adcs_ana_model (
  // core side
  input wire [2:0] ana_chan,
  output logic [9:0] ana_result
);
  timeunit 1ns;
  timeprecision 1ns;
  // the code carries the channel so a misrouted result shows up
  assign ana_result = {ana_chan, 7'h2B};
endmodule

// file: tb/adc_sequencer_regs_tb.sv
module adc_sequencer_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // csr written, upper byte address, expected result
  logic [27:0] rows [8] = '{28'h6000AC0, 28'h6922AC0, 28'h6244AC0, 28'h6B66AC0,
                            28'h6408AC0, 28'h6D2AAC0, 28'h664CAC0, 28'h6F6EAC0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_rd = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_word = 1'b0;
  logic ext_trigger_n = 1'b1;
  logic [3:0] cpu_addr = 4'h0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [15:0] cpu_rdata, rd_val, v;
  logic [7:0] csr;
  logic [3:0] a;
  logic cpu_rd_ack, ana_sample, conv_end_irq;
  logic [2:0] ana_chan;
  logic [9:0] ana_result;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  always #5 clk = ~clk;
  adcs_top DUT (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
    .cpu_wr(cpu_wr), .cpu_word(cpu_word), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rd_ack(cpu_rd_ack), .ext_trigger_n(ext_trigger_n), .ana_chan(ana_chan),
    .ana_sample(ana_sample), .ana_result(ana_result), .conv_end_irq(conv_end_irq));
  adcs_ana_model core (.ana_chan(ana_chan), .ana_result(ana_result));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] ad, input logic [7:0] d);
    @(negedge clk);
    cpu_addr = ad;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask
  task rd(input logic [3:0] ad, input logic w);
    @(negedge clk);
    cpu_addr = ad;
    cpu_word = w;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    chk({15'h0000, cpu_rd_ack}, 16'h0001);
    rd_val = cpu_rdata;
  endtask
  // slack allows for reads made while a scan pass was already under way
  task wait_irq(input int lim, input int slack);
    n = 0;
    while (conv_end_irq !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n > lim - slack && n <= lim + 8), 16'h0001);
  endtask
  task quiet(input int len);
    n = 0;
    repeat (len) begin
      @(negedge clk);
      n += (ana_sample !== 1'b0);
    end
    chk(16'(n), 16'h0000);
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd(4'h0, 1'b1);
    chk(rd_val, 16'h0000);
    rd(4'h9, 1'b0);
    chk(rd_val, 16'h007E);
    rd(4'hA, 1'b0);
    chk(rd_val, 16'h0000);
    foreach (rows[i]) begin
      {csr, a, v} = rows[i];
      wr(4'h8, csr);
      wait_irq(csr[3] ? 70 : 134, 8);
      wr(4'h8, csr & 8'h5F);
      chk({15'h0000, conv_end_irq}, 16'h0001);
      rd(4'h8, 1'b0);
      chk(rd_val, {8'h00, csr ^ 8'hA0});
      wr(4'h8, csr & 8'h5F);
      wr(4'h8, 8'hC0);
      chk({15'h0000, conv_end_irq}, 16'h0000);
      rd(a, 1'b0);
      chk(rd_val, {8'h00, v[15:8]});
      rd(a + 4'h1, 1'b0);
      chk(rd_val, {8'h00, v[7:0]});
      wr(a, 8'hFF);
      rd(a, 1'b1);
      chk(rd_val, v);
    end
    wr(4'h8, 8'h7B);
    wait_irq(268, 8);
    for (int k = 0; k < 4; k++) begin
      rd(4'(2 * k), 1'b1);
      chk(rd_val, {3'(k), 7'h2B, 6'h00});
    end
    rd(4'h8, 1'b0);
    chk(rd_val, 16'h00FB);
    wr(4'h8, 8'h7B);
    wait_irq(264, 30);
    rd(4'h8, 1'b0);
    chk(rd_val, 16'h00FB);
    wr(4'h8, 8'h9B);
    chk({15'h0000, conv_end_irq}, 16'h0000);
    quiet(150);
    wr(4'h9, 8'h80);
    rd(4'h9, 1'b0);
    chk(rd_val, 16'h00FE);
    rd(4'h8, 1'b0);
    chk(rd_val, 16'h009B);
    wr(4'h8, 8'h46);
    ext_trigger_n = 1'b0;
    wait_irq(134, 8);
    ext_trigger_n = 1'b1;
    rd(4'h8, 1'b0);
    chk(rd_val, 16'h00C6);
    wr(4'h8, 8'h46);
    wr(4'h9, 8'h00);
    ext_trigger_n = 1'b0;
    quiet(150);
    wr(4'h8, 8'h7B);
    repeat (20) @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(4'h2, 1'b1);
    chk(rd_val, 16'h0000);
    rd(4'h8, 1'b0);
    chk(rd_val, 16'h0000);
    complete_run();
  end
endmodule
bind adcs_top adcs_top_properties checker_i (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
  .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_word(cpu_word), .cpu_rdata(cpu_rdata),
  .cpu_rd_ack(cpu_rd_ack), .ana_chan(ana_chan), .ana_sample(ana_sample),
  .conv_end_irq(conv_end_irq));
